// ==== hw/l1cm_maint.sv ====
// L1 cache maintenance register block: decodes maintenance writes and drives one operation at a time.
// Assumes the core presents one access at a time and holds it until taken, and that the cache
// arrays acknowledge each operation with a one-cycle done pulse on the same clock.
//
// Contract
// [RULE1] Unprivileged access answered with bus fault.
// [RULE2] Invalidate-all write clears instruction cache.
// [RULE3] Branch predictor location reads zero, ignored.
// [RULE4] Address operand keeps bits 31 to 5.
// [RULE5] Each address register decodes its own operation.
// [RULE6] Set/way registers drop reserved bits, read zero.
// [RULE7] Set/way operand targets exactly one line.
// [RULE8] Operations complete strictly in issue order.
// [RULE9] Maintenance faults reported asynchronously, never lockup.
// [RULE10] Barrier held until operations have finished.
// [RULE11] Requester puts barrier before maintenance operation.
// [RULE12] Requester invalidates caches before first enable.
// [RULE13] Requester invalidates before re-enable if memory changed.
// [RULE14] Requester cleans data cache when disabling it.
// [RULE15] Cache enables sit at config bits 16, 17.
// [RULE16] Requester issues data then instruction barrier.
// [RULE17] Self-modifying code: clean, invalidate, barriers.
// [RULE18] Whole data cache reachable by set/way sweep.
// [RULE19] Address operation acts only on present line.
`timescale 1ns/1ns

module l1cm_maint
  import l1cm_pkg::*;
(
  input  wire logic               ref_clk,        // Processor clock, 10 MHz.
  input  wire logic               rst_b,          // Asynchronous reset, active low.
  input  wire logic               ce,             // Clock enable, freezes all state while low.
  input  wire logic               req_valid,      // Access to the maintenance space is offered.
  input  wire logic               req_write,      // High for a store, low for a load.
  input  wire logic               req_priv,       // High when the access is privileged.
  input  wire logic [31:0]        req_addr,       // Byte address of the access.
  input  wire logic [31:0]        req_wdata,      // Store data.
  output logic                    req_ready,      // Access is taken in a cycle where this is high.
  output logic                    resp_valid,     // One-cycle answer to a taken access.
  output logic                    resp_fault,     // Answer carries a bus fault.
  output logic [31:0]             resp_rdata,     // Load data, always zero.
  input  wire logic               dsb_req,        // Data barrier waiting in the core.
  output logic                    dsb_ack,        // One-cycle release of the barrier.
  output logic                    op_valid,       // Operation offered to the cache arrays.
  output l1cm_pkg::l1cm_op_t      op_code,        // Which operation.
  output logic [31:0]             op_operand,     // Masked address or set/way word.
  input  wire logic               op_done,        // Arrays finished the offered operation.
  input  wire logic               op_error,       // Arrays report a fault with the done pulse.
  output logic                    async_fault,    // One-cycle imprecise bus fault pulse.
  input  wire logic [31:0]        ccr_value,      // Config control register, held outside.
  output logic                    dcache_on,      // Registered data cache enable.
  output logic                    icache_on       // Registered instruction cache enable.
);
  import l1cm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // All state of the block in one word.
  typedef struct packed {
    l1cm_state_t state;        // Sequencer state.
    logic        req_ready;    // Registered ready.
    logic        resp_valid;   // Registered answer strobe.
    logic        resp_fault;   // Registered fault flag of the answer.
    logic [31:0] resp_rdata;   // Registered load data.
    logic        dsb_ack;      // Registered barrier release.
    logic        op_valid;     // Registered operation strobe.
    l1cm_op_t    op_code;      // Registered operation code.
    logic [31:0] op_operand;   // Registered operand.
    logic        async_fault;  // Registered fault pulse.
    logic        dcache_on;    // Registered data cache enable.
    logic        icache_on;    // Registered instruction cache enable.
  } l1cm_regs_t;

  l1cm_regs_t  st;             // Current state.
  l1cm_regs_t  next_st;        // Next state.
  logic        take;           // Access taken this cycle.
  l1cm_op_t    dec_op;         // Operation decoded from the address.
  logic [31:0] dec_mask;       // Operand mask for that operation.

  assign take = ce && req_valid && st.req_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode. Unlisted addresses, the reserved hole and the branch predictor
  // location decode to no operation, so they read zero and drop writes.
  always_comb
  begin
    dec_op   = L1CM_OP_NONE;
    dec_mask = L1CM_ZERO_WORD;
    case (req_addr)
      // [RULE2] Invalidate all.
      L1CM_ADDR_IINV_ALL:
      begin
        dec_op   = L1CM_OP_IINV_ALL;
        dec_mask = L1CM_ZERO_WORD;
      end
      // [RULE5] Per-register decode.
      L1CM_ADDR_IINV_POU:
      begin
        dec_op   = L1CM_OP_IINV_POU;
        dec_mask = L1CM_ADDR_OPND_MASK;
      end
      L1CM_ADDR_DINV_POC:
      begin
        dec_op   = L1CM_OP_DINV_POC;
        dec_mask = L1CM_ADDR_OPND_MASK;
      end
      L1CM_ADDR_DCLN_POU:
      begin
        dec_op   = L1CM_OP_DCLN_POU;
        dec_mask = L1CM_ADDR_OPND_MASK;
      end
      L1CM_ADDR_DCLN_POC:
      begin
        dec_op   = L1CM_OP_DCLN_POC;
        dec_mask = L1CM_ADDR_OPND_MASK;
      end
      L1CM_ADDR_DCI_POC:
      begin
        dec_op   = L1CM_OP_DCI_POC;
        dec_mask = L1CM_ADDR_OPND_MASK;
      end
      // [RULE6] Set/way registers.
      L1CM_ADDR_DINV_SW:
      begin
        dec_op   = L1CM_OP_DINV_SW;
        dec_mask = L1CM_SW_OPND_MASK;
      end
      L1CM_ADDR_DCLN_SW:
      begin
        dec_op   = L1CM_OP_DCLN_SW;
        dec_mask = L1CM_SW_OPND_MASK;
      end
      L1CM_ADDR_DCI_SW:
      begin
        dec_op   = L1CM_OP_DCI_SW;
        dec_mask = L1CM_SW_OPND_MASK;
      end
      // [RULE3] Branch predictor ignored.
      L1CM_ADDR_BP_INV_ALL:
      begin
        dec_op   = L1CM_OP_NONE;
        dec_mask = L1CM_ZERO_WORD;
      end
      default:
      begin
        dec_op   = L1CM_OP_NONE;
        dec_mask = L1CM_ZERO_WORD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic. Only one operation is ever outstanding; the access port stalls
  // while it runs. That costs throughput but makes issue order the completion order.
  always_comb
  begin
    next_st             = st;
    next_st.resp_valid  = 1'b0;
    next_st.resp_fault  = 1'b0;
    next_st.resp_rdata  = L1CM_ZERO_WORD;
    next_st.dsb_ack     = 1'b0;
    next_st.async_fault = 1'b0;
    // [RULE15] Cache enable bits.
    next_st.dcache_on   = ccr_value[L1CM_DATA_CACHE_ENABLE_BIT_BIT];
    next_st.icache_on   = ccr_value[L1CM_INSTR_CACHE_ENABLE_BIT_BIT];
    case (st.state)
      L1CM_ST_IDLE:
      begin
        if (take)
        begin
          next_st.resp_valid = 1'b1;
          // [RULE1] Unprivileged gets fault.
          if (!req_priv)
          begin
            next_st.resp_fault = 1'b1;
          end
          else if (req_write && (dec_op != L1CM_OP_NONE))
          begin
            // [RULE4] Address operand masked; set/way operand masked likewise.
            // [RULE7] One line selected.
            // [RULE18] Every set/way accepted.
            next_st.op_valid   = 1'b1;
            next_st.op_code    = dec_op;
            next_st.op_operand = req_wdata & dec_mask;
            next_st.state      = L1CM_ST_BUSY;
            next_st.req_ready  = 1'b0;
          end
        end
        else if (dsb_req && !st.dsb_ack)
        begin
          // [RULE10] Barrier released only when idle.
          next_st.dsb_ack = 1'b1;
        end
      end
      L1CM_ST_BUSY:
      begin
        // [RULE8] Hold until the arrays finish.
        // [RULE19] Arrays act on the one line only.
        if (op_done)
        begin
          next_st.op_valid   = 1'b0;
          next_st.op_code    = L1CM_OP_NONE;
          next_st.state      = L1CM_ST_IDLE;
          next_st.req_ready  = 1'b1;
          // [RULE9] Imprecise fault pulse.
          next_st.async_fault = op_error;
        end
      end
      default:
      begin
        next_st.state     = L1CM_ST_IDLE;
        next_st.op_valid  = 1'b0;
        next_st.req_ready = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register with clock enable; reset loads constants only.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st             <= '0;
      st.state       <= L1CM_ST_IDLE;
      st.req_ready   <= 1'b1;
      st.op_code     <= L1CM_OP_NONE;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register.
  assign req_ready   = st.req_ready;
  assign resp_valid  = st.resp_valid;
  assign resp_fault  = st.resp_fault;
  assign resp_rdata  = st.resp_rdata;
  assign dsb_ack     = st.dsb_ack;
  assign op_valid    = st.op_valid;
  assign op_code     = st.op_code;
  assign op_operand  = st.op_operand;
  assign async_fault = st.async_fault;
  assign dcache_on   = st.dcache_on;
  assign icache_on   = st.icache_on;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks. They are written for ce held high; cycles with ce low are skipped.
  default clocking l1cm_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b || !ce);

  a_unpriv_fault: assert property (take && !req_priv |=> resp_valid && resp_fault && !op_valid) // [RULE1]
    else $error("unprivileged access not faulted");

  a_priv_no_fault: assert property (take && req_priv |=> resp_valid && !resp_fault) // [RULE1]
    else $error("privileged access faulted");

  a_iinv_all_op: assert property (take && req_priv && req_write && req_addr == L1CM_ADDR_IINV_ALL // [RULE2]
                                  |=> op_valid && op_code == L1CM_OP_IINV_ALL && op_operand == L1CM_ZERO_WORD)
    else $error("invalidate all not issued with zero operand");

  a_bp_ignored: assert property (take && req_addr == L1CM_ADDR_BP_INV_ALL // [RULE3]
                                 |=> !op_valid && resp_rdata == L1CM_ZERO_WORD)
    else $error("branch predictor access had an effect");

  a_addr_operand: assert property (take && req_priv && req_write && dec_mask == L1CM_ADDR_OPND_MASK // [RULE4]
                                   |=> op_valid && op_operand == ($past(req_wdata) & L1CM_ADDR_OPND_MASK))
    else $error("address operand wrong");

  a_addr_decode: assert property (take && req_priv && req_write && req_addr == L1CM_ADDR_DCLN_POU // [RULE5]
                                  |=> op_code == L1CM_OP_DCLN_POU ##1 op_code == L1CM_OP_DCLN_POU || !op_valid)
    else $error("clean to unification decoded wrong");

  a_sw_operand: assert property (take && req_priv && req_write && dec_mask == L1CM_SW_OPND_MASK // [RULE6]
                                 |=> op_operand == ($past(req_wdata) & L1CM_SW_OPND_MASK) && op_operand[0] == 1'b0)
    else $error("set/way operand wrong");

  a_read_zero: assert property (take && !req_write |=> resp_rdata == L1CM_ZERO_WORD && !op_valid) // [RULE6]
    else $error("read returned data or started an operation");

  a_in_order: assert property (op_valid && !op_done |=> op_valid && $stable(op_operand) && !req_ready) // [RULE8]
    else $error("operation dropped or overtaken");

  a_async_fault: assert property (op_valid && op_done && op_error |=> async_fault && !op_valid) // [RULE9]
    else $error("maintenance fault not reported");

  a_dsb_hold: assert property (dsb_ack |-> !$past(op_valid) && !op_valid) // [RULE10]
    else $error("barrier released with operation pending");

  ////////////////////////////////////////////////////////////////////////////////
  // Port-level checks. They pin down the handshake timing that the core relies on,
  // so a later change to the sequencer that quietly adds or drops a cycle shows up
  // here rather than as a hang in the core's barrier logic.

  // [RULE8] Port closed while busy.
  // A second access taken while an operation runs could reach the arrays ahead of
  // the first, so the port must stay shut for the whole operation.
  a_ready_busy: assert property (op_valid |-> !req_ready) // [RULE8]
    else $error("access port open while an operation runs");

  // [RULE8] Idle code after retirement.
  // The arrays key on the code as well as the strobe; a stale code would let a
  // glitch on the strobe repeat the last operation.
  a_code_idle: assert property (!op_valid |-> op_code == L1CM_OP_NONE) // [RULE8]
    else $error("operation code left over while idle");

  // [RULE1] No answer without an access.
  // Every answer belongs to exactly one taken access.
  a_resp_owned: assert property (!take |=> !resp_valid) // [RULE1]
    else $error("answer given without a taken access");

  // [RULE10] No barrier release while busy.
  // A release from the busy state would let later loads pass the operation.
  a_dsb_busy: assert property (st.state == L1CM_ST_BUSY |=> !dsb_ack) // [RULE10]
    else $error("barrier released from the busy state");

  // [RULE9] Fault pulse only on retirement.
  // The fault is imprecise, so it may only follow a done pulse of the arrays.
  a_fault_pulse: assert property (async_fault |-> $past(op_done) && $past(op_valid)) // [RULE9]
    else $error("fault pulse without a retiring operation");

  // [RULE15] Data enable follows config bit 16.
  // The copies lag the config register by exactly one cycle.
  a_enable_follow: assert property (ccr_value[L1CM_DATA_CACHE_ENABLE_BIT_BIT] == 1'b1 |=> dcache_on) // [RULE15]
    else $error("data cache enable did not follow its config bit");

  // [RULE15] Instruction enable follows too.
  a_ienable_follow: assert property (ccr_value[L1CM_INSTR_CACHE_ENABLE_BIT_BIT] == 1'b0 |=> !icache_on) // [RULE15]
    else $error("instruction cache enable did not follow its config bit");

endmodule // l1cm_maint

// ==== hw/l1cm_pkg.sv ====
// Package for the L1 cache maintenance register block.
// Holds register addresses, operand masks, field positions and the operation codes.
// Assumes its users import it whole and need no other shared definitions.
package l1cm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register addresses inside the private peripheral region.
  localparam logic [31:0] L1CM_ADDR_IINV_ALL     = 32'hE000EF50; // Instruction invalidate all.
  localparam logic [31:0] L1CM_ADDR_RSVD_54      = 32'hE000EF54; // Reserved hole, reads zero.
  localparam logic [31:0] L1CM_ADDR_IINV_POU     = 32'hE000EF58; // Instruction invalidate by address.
  localparam logic [31:0] L1CM_ADDR_DINV_POC     = 32'hE000EF5C; // Data invalidate by address.
  localparam logic [31:0] L1CM_ADDR_DINV_SW      = 32'hE000EF60; // Data invalidate by set/way.
  localparam logic [31:0] L1CM_ADDR_DCLN_POU     = 32'hE000EF64; // Data clean by address, unification.
  localparam logic [31:0] L1CM_ADDR_DCLN_POC     = 32'hE000EF68; // Data clean by address, coherency.
  localparam logic [31:0] L1CM_ADDR_DCLN_SW      = 32'hE000EF6C; // Data clean by set/way.
  localparam logic [31:0] L1CM_ADDR_DCI_POC      = 32'hE000EF70; // Data clean and invalidate by address.
  localparam logic [31:0] L1CM_ADDR_DCI_SW       = 32'hE000EF74; // Data clean and invalidate by set/way.
  localparam logic [31:0] L1CM_ADDR_BP_INV_ALL   = 32'hE000EF78; // Branch predictor hole, read zero.

  ////////////////////////////////////////////////////////////////////////////////
  // Operand layouts.
  localparam logic [31:0] L1CM_ADDR_OPND_MASK    = 32'hFFFFFFE0; // Address bits 31 down to 5 kept.
  localparam logic [31:0] L1CM_SW_OPND_MASK      = 32'hC0003FE0; // Way 31:30 and set 13:5 kept.
  localparam logic [31:0] L1CM_ZERO_WORD         = 32'h00000000; // Read data of every register.
  localparam int          L1CM_SW_SET_LSB        = 5;            // Set index starts at this bit.
  localparam int          L1CM_SW_WAY_MSB        = 30;           // Way index aligns toward this bit.

  ////////////////////////////////////////////////////////////////////////////////
  // Fields of registers outside this block.
  localparam int          L1CM_DATA_CACHE_ENABLE_BIT_BIT        = 16;           // Data cache enable in config control.
  localparam int          L1CM_INSTR_CACHE_ENABLE_BIT_BIT        = 17;           // Instruction cache enable.
  localparam int          L1CM_CSIZE_WAY_LSB     = 3;            // Way count minus one, low bit.
  localparam int          L1CM_CSIZE_WAY_W       = 10;           // Way count minus one, width.
  localparam int          L1CM_CSIZE_SET_LSB     = 13;           // Set count minus one, low bit.
  localparam int          L1CM_CSIZE_SET_W       = 15;           // Set count minus one, width.

  ////////////////////////////////////////////////////////////////////////////////
  // Operations handed to the cache arrays.
  typedef enum logic [3:0] {
    L1CM_OP_NONE,
    L1CM_OP_IINV_ALL,
    L1CM_OP_IINV_POU,
    L1CM_OP_DINV_POC,
    L1CM_OP_DINV_SW,
    L1CM_OP_DCLN_POU,
    L1CM_OP_DCLN_POC,
    L1CM_OP_DCLN_SW,
    L1CM_OP_DCI_POC,
    L1CM_OP_DCI_SW
  } l1cm_op_t;

  // Sequencer states.
  typedef enum logic [0:0] {
    L1CM_ST_IDLE,
    L1CM_ST_BUSY
  } l1cm_state_t;

endpackage : l1cm_pkg

// ==== test/l1cm_array_model.sv ====
// Behavioural model of the cache arrays that carry out maintenance operations.
// Assumes the block holds op_valid until the edge after op_done and issues one operation at a time.
`timescale 1ns/1ns

module l1cm_array_model
(
  input  wire logic       ref_clk,   // Processor clock.
  input  wire logic       rst_b,     // Asynchronous reset, active low.
  input  wire logic       op_valid,  // Operation offered by the block.
  input  wire logic [2:0] dly,       // Cycles to stall before answering.
  input  wire logic       err_in,    // Answer the next operation with a fault.
  output logic            op_done,   // One-cycle completion pulse.
  output logic            op_error   // Fault flag, meaningful only with op_done.
);
  logic [2:0] cnt;    // Cycles spent on the current operation.
  logic       fired;  // Current operation already answered.
  logic       err_q;  // Fault captured for the answer.
  logic       tog;    // Filler that changes every cycle, so a stray sample is never clean.

  //////////////////////////////////////////////////////////////////////////////
  // Each operation is answered exactly once; the stall lets a barrier meet a busy block.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {cnt, fired, err_q, op_done, tog} <= '0;
    end
    else
    begin
      tog <= ~tog;
      op_done <= 1'b0;
      if (!op_valid)
      begin
        cnt <= '0;
        fired <= 1'b0;
      end
      else if (!fired && cnt >= dly)
      begin
        op_done <= 1'b1;
        fired <= 1'b1;
        err_q <= err_in;
      end
      else if (!fired)
      begin
        cnt <= cnt + 3'h1;
      end
    end
  end

  // The fault flag only carries meaning beside the done pulse.
  assign op_error = op_done ? err_q : tog;
endmodule // l1cm_array_model

// ==== test/tb_l1cm_maint.sv ====
// Self-checking testbench for the maintenance register block, acting as the core.
// Assumes the array model answers every operation and the block needs no other stimulus.
`timescale 1ns/1ns

module tb_l1cm_maint;
  import l1cm_pkg::*;
  logic        ref_clk, rst_b, ce, req_valid, req_write, req_priv, req_ready, resp_valid, resp_fault;
  logic        dsb_req, dsb_ack, op_valid, op_done, op_error, async_fault, dcache_on, icache_on, err_in;
  logic [31:0] req_addr, req_wdata, resp_rdata, op_operand, ccr_value, seed, d;
  logic [2:0]  dly;
  l1cm_op_t    op_code;
  int          failures, samples_checked, i, n;
  logic        wr, pr, e;
  // Register table in the order of the operation codes.
  logic [31:0] addr_t [9] = '{L1CM_ADDR_IINV_ALL, L1CM_ADDR_IINV_POU, L1CM_ADDR_DINV_POC, L1CM_ADDR_DINV_SW,
    L1CM_ADDR_DCLN_POU, L1CM_ADDR_DCLN_POC, L1CM_ADDR_DCLN_SW, L1CM_ADDR_DCI_POC, L1CM_ADDR_DCI_SW};
  l1cm_op_t    code_t [9] = '{L1CM_OP_IINV_ALL, L1CM_OP_IINV_POU, L1CM_OP_DINV_POC, L1CM_OP_DINV_SW,
    L1CM_OP_DCLN_POU, L1CM_OP_DCLN_POC, L1CM_OP_DCLN_SW, L1CM_OP_DCI_POC, L1CM_OP_DCI_SW};

  l1cm_maint u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .req_valid(req_valid), .req_write(req_write),
    .req_priv(req_priv), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_fault(resp_fault), .resp_rdata(resp_rdata), .dsb_req(dsb_req),
    .dsb_ack(dsb_ack), .op_valid(op_valid), .op_code(op_code), .op_operand(op_operand), .op_done(op_done),
    .op_error(op_error), .async_fault(async_fault), .ccr_value(ccr_value), .dcache_on(dcache_on),
    .icache_on(icache_on));
  l1cm_array_model u_arr (.ref_clk(ref_clk), .rst_b(rst_b), .op_valid(op_valid), .dly(dly), .err_in(err_in),
    .op_done(op_done), .op_error(op_error));

  //////////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Pseudo-random sequence; a fixed start keeps every run identical.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Operand expected on the array port: set/way keeps way and set only, address keeps bits 31 to 5.
  function automatic logic [31:0] exp_opnd(input int k, input logic [31:0] w);
    if (k == 0)
      return 32'h00000000;
    if (k == 3 || k == 6 || k == 8)
      return w & L1CM_SW_OPND_MASK;
    return w & L1CM_ADDR_OPND_MASK;
  endfunction

  // Single comparison point; every check is counted.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // One access held until taken, then the one-cycle answer and the operation start are checked.
  task automatic access(input logic w, input logic p, input logic [31:0] a, input logic [31:0] v,
                        input l1cm_op_t c, input logic [31:0] o);
    int m;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_priv <= p;
    req_addr <= a;
    req_wdata <= v;
    m = 0;
    do
    begin
      @(negedge ref_clk);
      m++;
    end
    while (req_ready !== 1'b1 && m < 60);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    @(negedge ref_clk);
    check(resp_valid, 1'b1);
    check(resp_fault, !p);
    check(resp_rdata, L1CM_ZERO_WORD);
    check(op_code, c);
    if (c != L1CM_OP_NONE)
      check(op_operand, o);
  endtask

  // Wait for the running operation to retire, then check the fault pulse and readiness.
  task automatic wait_idle(input logic f);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (op_valid !== 1'b0 && n < 60);
    check(async_fault, f);
    check(req_ready, 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well beyond the under a thousand cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_sim;
  end

  // Main sequence.
  initial
  begin
    {ce, rst_b, req_valid, req_write, req_priv, dsb_req, err_in} = 7'h40;
    {req_addr, req_wdata, ccr_value} = '0;
    {failures, samples_checked} = '0;
    dly = 3'h0;
    seed = 32'h0000003F;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    check({req_ready, resp_valid, op_valid, dsb_ack, async_fault}, 5'h10);
    // invalidate both caches, sweeping 4 sets and 2 ways in the set/way layout
    access(1'b1, 1'b1, L1CM_ADDR_IINV_ALL, 32'hFFFFFFFF, L1CM_OP_IINV_ALL, 32'h0);
    wait_idle(1'b0);
    for (int k = 0; k < 8; k++)
    begin
      d = {k[0], 30'h0, 1'b1} | (k[2:1] << L1CM_SW_SET_LSB) | 32'h3FFFC01E;
      access(1'b1, 1'b1, L1CM_ADDR_DINV_SW, d, L1CM_OP_DINV_SW, d & L1CM_SW_OPND_MASK);
      wait_idle(1'b0);
    end
    // clean one data cache line (set 3, way bit 31) by set/way before its enable may drop
    access(1'b1, 1'b1, L1CM_ADDR_DCLN_SW, d, L1CM_OP_DCLN_SW, d & L1CM_SW_OPND_MASK);
    wait_idle(1'b0);
    // enables change only after the invalidate sweep above
    // enables follow config bits 16 and 17 one cycle later
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      @(posedge ref_clk);
      ccr_value <= seed;
      @(posedge ref_clk);
      @(negedge ref_clk);
      check({dcache_on, icache_on}, {seed[L1CM_DATA_CACHE_ENABLE_BIT_BIT], seed[L1CM_INSTR_CACHE_ENABLE_BIT_BIT]});
    end
    // Holes, branch predictor place and an unmapped word: no operation, zero data.
    for (int k = 0; k < 6; k++)
      access(k[0], 1'b1, (k < 2) ? L1CM_ADDR_RSVD_54 : (k < 4) ? L1CM_ADDR_BP_INV_ALL : 32'hE000EF7C,
             seed, L1CM_OP_NONE, 32'h0);
    // Random mix of privilege, direction, register, stall and array fault.
    for (int k = 0; k < 60; k++)
    begin
      seed = lfsr(seed);
      i = seed[7:0] % 9;
      wr = seed[8] | seed[9];
      pr = seed[10] | seed[11];
      e = seed[15] & seed[16];
      d = lfsr(seed);
      @(posedge ref_clk);
      dly <= seed[14:12];
      err_in <= e;
      access(wr, pr, addr_t[i], d, (wr && pr) ? code_t[i] : L1CM_OP_NONE, exp_opnd(i, d));
      if (wr && pr)
        wait_idle(e);
    end
    // back-to-back: the second waits for the first and keeps its own code
    @(posedge ref_clk);
    dly <= 3'h7;
    err_in <= 1'b0;
    access(1'b1, 1'b1, L1CM_ADDR_DCLN_POU, d, L1CM_OP_DCLN_POU, d & L1CM_ADDR_OPND_MASK);
    access(1'b1, 1'b1, L1CM_ADDR_IINV_POU, d, L1CM_OP_IINV_POU, d & L1CM_ADDR_OPND_MASK);
    // the core closes the group with a barrier
    // a barrier raised while busy is released only after the operation retires
    @(posedge ref_clk);
    dsb_req <= 1'b1;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
      if (op_valid === 1'b1)
        check(dsb_ack, 1'b0);
    end
    while (dsb_ack !== 1'b1 && n < 60);
    check({dsb_ack, op_valid}, 2'h2);
    @(posedge ref_clk);
    dsb_req <= 1'b0;
    end_sim;
  end
endmodule // tb_l1cm_maint
